// [rtl/rrbsa_pkg.sv]
package rrbsa_pkg;

    // ========================================================
    // register addresses
    localparam logic [5:0] ADDR_CHANNEL      = 6'h00;
    localparam logic [5:0] ADDR_TX_LENGTH    = 6'h01;
    localparam logic [5:0] ADDR_TX_CONTROL   = 6'h02;
    localparam logic [5:0] ADDR_TX_CONFIG    = 6'h03;
    localparam logic [5:0] ADDR_TX_FLAGS     = 6'h04;
    localparam logic [5:0] ADDR_RX_CONTROL   = 6'h05;
    localparam logic [5:0] ADDR_RX_CONFIG    = 6'h06;
    localparam logic [5:0] ADDR_RX_FLAGS     = 6'h07;
    localparam logic [5:0] ADDR_POWER        = 6'h0B;
    localparam logic [5:0] ADDR_CRYSTAL      = 6'h0C;
    localparam logic [5:0] ADDR_PIN_CONFIG   = 6'h0D;
    localparam logic [5:0] ADDR_PIN_LEVEL    = 6'h0E;
    localparam logic [5:0] ADDR_XACT_CONFIG  = 6'h0F;
    localparam logic [5:0] ADDR_FRAMING      = 6'h10;
    localparam logic [5:0] ADDR_SHORT_THOLD  = 6'h11;
    localparam logic [5:0] ADDR_LONG_THOLD   = 6'h12;
    localparam logic [5:0] ADDR_STRENGTH     = 6'h13;
    localparam logic [5:0] ADDR_EOP_CONTROL  = 6'h14;
    localparam logic [5:0] ADDR_SEED_LOW     = 6'h15;
    localparam logic [5:0] ADDR_SEED_HIGH    = 6'h16;
    localparam logic [5:0] ADDR_TX_CRC_LOW   = 6'h17;
    localparam logic [5:0] ADDR_TX_CRC_HIGH  = 6'h18;
    localparam logic [5:0] ADDR_RX_CRC_LOW   = 6'h19;
    localparam logic [5:0] ADDR_RX_CRC_HIGH  = 6'h1A;
    localparam logic [5:0] ADDR_TRIM_LOW     = 6'h1B;
    localparam logic [5:0] ADDR_TRIM_HIGH    = 6'h1C;
    localparam logic [5:0] ADDR_STATE_OVRD   = 6'h1D;
    localparam logic [5:0] ADDR_RX_OVRD      = 6'h1E;
    localparam logic [5:0] ADDR_TX_OVRD      = 6'h1F;
    localparam logic [5:0] ADDR_OUT_BUFFER   = 6'h20;
    localparam logic [5:0] ADDR_IN_BUFFER    = 6'h21;
    localparam logic [5:0] ADDR_START_CODE   = 6'h22;
    localparam logic [5:0] ADDR_SPREAD_CODE  = 6'h23;
    localparam logic [5:0] ADDR_LEAD_IN      = 6'h24;
    localparam logic [5:0] ADDR_MAKER_ID     = 6'h25;
    localparam logic [5:0] ADDR_CLK_OVRD     = 6'h27;
    localparam logic [5:0] ADDR_CLK_GATE     = 6'h28;
    localparam logic [5:0] ADDR_RX_ABORT     = 6'h29;
    localparam logic [5:0] ADDR_CAL_TIME     = 6'h32;
    localparam logic [5:0] ADDR_CAL_OFFSET   = 6'h35;
    localparam logic [5:0] ADDR_ANALOG       = 6'h39;

    // ========================================================
    // fields and serial command layout
    localparam int   BIT_TX_START       = 7;
    localparam int   BIT_TX_FLUSH       = 6;
    localparam int   BIT_CMD_WRITE      = 7;
    localparam int   BIT_CMD_INCREMENT  = 6;
    localparam int   REG_COUNT          = 64;
    localparam logic [7:0] MAKER_ID     = 8'h5A; // arbitrary value
    localparam logic [7:0] BYTE_ZERO    = 8'h00;
    localparam logic [2:0] LAST_BIT     = 3'h7;

    // ========================================================
    // types
    typedef logic [7:0] rrbsa_reg_t;
    typedef logic [REG_COUNT-1:0][7:0] rrbsa_bank_t;

    typedef struct packed {
        logic       isAddr;                 // first byte of a frame
        logic [7:0] data;
    } rrbsa_byte_t;

    typedef struct packed {
        logic [7:0]  txFlags;
        logic [7:0]  rxFlags;
        logic [7:0]  strength;
        logic [15:0] txCrc;
        logic [15:0] rxCrc;
        logic [7:0]  inData;
    } rrbsa_status_t;

    typedef struct packed {
        logic       txStart;
        logic       txFlush;
        logic       outPush;
        logic [7:0] outData;
        logic       inPop;
        logic       txFlagsRead;
    } rrbsa_ctl_t;

    // ========================================================
    // per-address write mask, read mask and reset value
    function automatic rrbsa_reg_t reg_write_mask(input logic [5:0] a);
        case (a)
            ADDR_CHANNEL:                         return 8'h7F;
            ADDR_TX_CONTROL:                      return 8'h3F;
            ADDR_TX_CONFIG:                       return 8'h3F;
            ADDR_RX_CONFIG:                       return 8'hDF;
            ADDR_POWER:                           return 8'hEF;
            ADDR_CRYSTAL:                         return 8'hE7;
            ADDR_PIN_LEVEL:                       return 8'hF0;
            ADDR_XACT_CONFIG:                     return 8'hBF;
            ADDR_SHORT_THOLD, ADDR_TRIM_HIGH:     return 8'h0F;
            ADDR_LONG_THOLD:                      return 8'h1F;
            ADDR_STATE_OVRD:                      return 8'h39;
            ADDR_RX_OVRD:                         return 8'hFE;
            ADDR_TX_LENGTH, ADDR_RX_CONTROL, ADDR_PIN_CONFIG, ADDR_FRAMING,
            ADDR_EOP_CONTROL, ADDR_SEED_LOW, ADDR_SEED_HIGH, ADDR_TRIM_LOW,
            ADDR_TX_OVRD, ADDR_START_CODE, ADDR_SPREAD_CODE, ADDR_LEAD_IN,
            ADDR_CLK_OVRD, ADDR_CLK_GATE, ADDR_RX_ABORT, ADDR_CAL_TIME,
            ADDR_CAL_OFFSET, ADDR_ANALOG:         return 8'hFF;
            default:                              return 8'h00;
        endcase
    endfunction

    function automatic rrbsa_reg_t reg_read_mask(input logic [5:0] a);
        case (a)
            ADDR_TX_CONTROL:                      return 8'hBF;
            ADDR_STATE_OVRD, ADDR_CLK_OVRD, ADDR_CLK_GATE, ADDR_RX_ABORT,
            ADDR_CAL_TIME, ADDR_CAL_OFFSET, ADDR_ANALOG:
                                                  return 8'h00;
            default:                              return reg_write_mask(a);
        endcase
    endfunction

    function automatic rrbsa_reg_t reg_reset(input logic [5:0] a);
        case (a)
            ADDR_CHANNEL:      return 8'h48;
            ADDR_TX_CONTROL:   return 8'h03;
            ADDR_TX_CONFIG:    return 8'h05;
            ADDR_RX_CONFIG:    return 8'h92;
            ADDR_POWER:        return 8'hA0;
            ADDR_CRYSTAL:      return 8'h04;
            ADDR_XACT_CONFIG:  return 8'h80;
            ADDR_FRAMING:      return 8'hA5;
            ADDR_SHORT_THOLD:  return 8'h04;
            ADDR_LONG_THOLD:   return 8'h0A;
            ADDR_EOP_CONTROL:  return 8'hA4;
            ADDR_START_CODE:   return 8'h82;
            ADDR_SPREAD_CODE:  return 8'h6F;
            ADDR_LEAD_IN:      return 8'h02;
            ADDR_CAL_TIME:     return 8'h03;
            default:           return 8'h00;
        endcase
    endfunction

endpackage

// [rtl/rrbsa_link.sv]
`timescale 1ns/10ps

module rrbsa_link
    import rrbsa_pkg::*;
(
    input  wire logic        sclk,     // serial clock from master
    input  wire logic        rst,      // async reset, active high
    input  wire logic        selN,     // frame select, active low
    input  wire logic        mosi,     // serial data in
    input  wire logic [7:0]  rdHold,   // read byte, quasi-static
    output rrbsa_byte_t      rxByte,   // last complete byte
    output logic             byteTog,  // toggles per byte
    output logic             misoOut,  // serial data out
    output logic             misoEnN   // low while driving
);

    logic       frameRst;
    logic [2:0] bitCnt;
    logic       firstByte;
    logic [6:0] shiftIn;
    logic [7:0] shiftOut;

    // select high ends the frame without needing a clock edge
    assign frameRst = rst | selN;

    // ========================================================
    // frame position
    always_ff @(posedge sclk or posedge frameRst) begin
        if (frameRst) begin
            bitCnt    <= 3'h0;
            firstByte <= 1'b1;
            misoEnN   <= 1'b1;
        end else begin
            bitCnt  <= bitCnt + 3'h1;
            misoEnN <= 1'b0;
            if (bitCnt == LAST_BIT) begin
                firstByte <= 1'b0;
            end
        end
    end

    // ========================================================
    // shifting; outgoing data changes on the rising edge
    always_ff @(posedge sclk or posedge frameRst) begin
        if (frameRst) begin
            shiftIn  <= 7'h00;
            shiftOut <= 8'h00;
            misoOut  <= 1'b0;
        end else begin
            shiftIn <= {shiftIn[5:0], mosi};
            if (bitCnt == 3'h0 && !firstByte) begin
                // core prefetched this byte during the gap
                misoOut  <= rdHold[7];
                shiftOut <= {rdHold[6:0], 1'b0};
            end else begin
                misoOut  <= shiftOut[7];
                shiftOut <= {shiftOut[6:0], 1'b0};
            end
        end
    end

    // ========================================================
    // byte hand-off; survives frame end so the toggle stays honest
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            rxByte  <= '0;
            byteTog <= 1'b0;
        end else if (bitCnt == LAST_BIT && !selN) begin
            rxByte  <= '{isAddr: firstByte, data: {shiftIn, mosi}};
            byteTog <= ~byteTog;
        end
    end

endmodule

// [rtl/rrbsa_bank.sv]
`timescale 1ns/10ps

module rrbsa_bank
    import rrbsa_pkg::*;
(
    input  wire logic        clock,     // core clock, 20 MHz
    input  wire logic        rst,       // async reset, active high
    input  wire logic        sclk,      // serial clock from master
    input  wire logic        selN,      // frame select, active low
    input  wire logic        mosi,      // serial data in
    output logic             misoOut,   // serial data out
    output logic             misoEnN,   // miso enable, low drives
    input  wire logic [3:0]  pinLevel,  // external pin levels
    input  wire logic        txDone,    // packet finished sending
    input  rrbsa_status_t    status,    // radio read-only state
    output rrbsa_bank_t      regBank,   // stored register image
    output rrbsa_ctl_t       ctl        // one-cycle radio commands
);

    rrbsa_bank_t regs;
    rrbsa_byte_t rxByte;
    logic        byteTog;
    logic        togSync1;
    logic        togSync2;
    logic        togSync3;
    logic [3:0]  pinSync1;
    logic [3:0]  pinSync2;
    logic [7:0]  rdHold;
    logic [5:0]  ptr;
    logic        isWrite;
    logic        incr;
    logic        byteEvt;
    logic        wrEn;
    logic [5:0]  fetchAddr;
    logic        fetchEn;
    logic [7:0]  fetchData;

    assign regBank = regs;

    // ========================================================
    // serial side; the only path into the bank besides txDone clearing the start bit
    rrbsa_link uLink (
        .sclk    (sclk),
        .rst     (rst),
        .selN    (selN),
        .mosi    (mosi),
        .rdHold  (rdHold),
        .rxByte  (rxByte),
        .byteTog (byteTog),
        .misoOut (misoOut),
        .misoEnN (misoEnN)
    );

    // ========================================================
    // crossings: byte event by toggle, pin levels two flops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            togSync1 <= 1'b0;
            togSync2 <= 1'b0;
            togSync3 <= 1'b0;
        end else begin
            togSync1 <= byteTog;
            togSync2 <= togSync1;
            togSync3 <= togSync2;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinSync1 <= 4'h0;
            pinSync2 <= 4'h0;
        end else begin
            pinSync1 <= pinLevel;
            pinSync2 <= pinSync1;
        end
    end

    // rxByte stood still for two core clocks before this fires
    assign byteEvt = togSync2 ^ togSync3;

    // ========================================================
    // command decode and address pointer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ptr     <= 6'h00;
            isWrite <= 1'b0;
            incr    <= 1'b0;
        end else if (byteEvt) begin
            if (rxByte.isAddr) begin
                ptr     <= rxByte.data[5:0];
                isWrite <= rxByte.data[BIT_CMD_WRITE];
                incr    <= rxByte.data[BIT_CMD_INCREMENT];
            end else begin
                ptr <= ptr + {5'h00, incr};
            end
        end
    end

    assign wrEn = byteEvt && !rxByte.isAddr && isWrite;

    // next byte to present: the new address, or the next in the burst
    always_comb begin
        if (rxByte.isAddr) begin
            fetchAddr = rxByte.data[5:0];
            fetchEn   = byteEvt && !rxByte.data[BIT_CMD_WRITE];
        end else begin
            fetchAddr = ptr + {5'h00, incr};
            fetchEn   = byteEvt && !isWrite;
        end
    end

    // ========================================================
    // storage, one process per entry
    for (genvar i = 0; i < REG_COUNT; i++) begin : gEntry
        localparam logic [5:0] IDX = 6'(i);
        if (IDX == ADDR_TX_CONTROL) begin : gTxCtl
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    regs[i] <= reg_reset(IDX);
                end else begin
                    if (wrEn && ptr == IDX) begin
                        regs[i][5:0] <= rxByte.data[5:0];
                    end
                    // a write of one beats a completion in the same cycle
                    if (wrEn && ptr == IDX && rxByte.data[BIT_TX_START]) begin
                        regs[i][BIT_TX_START] <= 1'b1;
                    end else if (txDone) begin
                        regs[i][BIT_TX_START] <= 1'b0;
                    end
                    regs[i][BIT_TX_FLUSH] <= 1'b0;
                end
            end
        end else begin : gPlain
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    regs[i] <= reg_reset(IDX);
                end else if (wrEn && ptr == IDX) begin
                    // masked bits keep their value
                    regs[i] <= (regs[i] & ~reg_write_mask(IDX))
                             | (rxByte.data & reg_write_mask(IDX));
                end
            end
        end
    end

    // ========================================================
    // read selection
    always_comb begin
        case (fetchAddr)
            ADDR_TX_FLAGS:    fetchData = status.txFlags;
            ADDR_RX_FLAGS:    fetchData = status.rxFlags;
            ADDR_STRENGTH:    fetchData = status.strength;
            ADDR_TX_CRC_LOW:  fetchData = status.txCrc[7:0];
            ADDR_TX_CRC_HIGH: fetchData = status.txCrc[15:8];
            ADDR_RX_CRC_LOW:  fetchData = status.rxCrc[7:0];
            ADDR_RX_CRC_HIGH: fetchData = status.rxCrc[15:8];
            ADDR_IN_BUFFER:   fetchData = status.inData;
            ADDR_MAKER_ID:    fetchData = MAKER_ID;
            ADDR_PIN_LEVEL:   fetchData = {regs[ADDR_PIN_LEVEL][7:4], pinSync2};
            // write-only and unmapped read as zero
            default:          fetchData = regs[fetchAddr] & reg_read_mask(fetchAddr);
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdHold <= BYTE_ZERO;
        end else if (fetchEn) begin
            rdHold <= fetchData;
        end
    end

    // ========================================================
    // commands to the radio, one cycle each
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctl <= '0;
        end else begin
            ctl.txStart <= wrEn && ptr == ADDR_TX_CONTROL
                         && rxByte.data[BIT_TX_START];
            ctl.txFlush <= wrEn && ptr == ADDR_TX_CONTROL
                         && rxByte.data[BIT_TX_FLUSH];
            ctl.outPush <= wrEn && ptr == ADDR_OUT_BUFFER;
            if (wrEn && ptr == ADDR_OUT_BUFFER) begin
                ctl.outData <= rxByte.data;
            end
            // prefetch also pops: a burst ending on the buffer loses one byte
            ctl.inPop       <= fetchEn && fetchAddr == ADDR_IN_BUFFER;
            ctl.txFlagsRead <= fetchEn && fetchAddr == ADDR_TX_FLAGS;
        end
    end

endmodule

// [dv/rrbsa_bank_props.sv]
`timescale 1ns/10ps
// ========================================
// port checker of the register bank
module rrbsa_bank_props
    import rrbsa_pkg::*;
(
    input wire logic   clock,    // core clock
    input wire logic   rst,      // async reset
    input wire logic   selN,     // frame select
    input wire logic   misoEnN,  // miso enable
    input wire logic   txDone,   // packet sent
    input rrbsa_bank_t regBank,  // register image
    input rrbsa_ctl_t  ctl       // radio commands
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic [3:0] idle;

    // frames land a few clocks late, so only trust long idle spans
    always_ff @(posedge clock or posedge rst) begin
        if (rst) idle <= 4'h0;
        else if (!selN) idle <= 4'h0;
        else if (idle != 4'hF) idle <= idle + 4'h1;
    end

    property p_reset_values;
        $fell(rst) |-> regBank[ADDR_CHANNEL] == 8'h48 && regBank[ADDR_POWER] == 8'hA0
            && regBank[ADDR_FRAMING] == 8'hA5 && regBank[ADDR_TX_CONTROL] == 8'h03;
    endproperty
    property p_chan_top;
        regBank[ADDR_CHANNEL][7] == 1'b0;
    endproperty
    property p_cfg_unused;
        regBank[ADDR_TX_CONFIG][7:6] == 2'b00;
    endproperty
    property p_ovrd_mask;
        (regBank[ADDR_STATE_OVRD] & 8'hC6) == 8'h00;
    endproperty
    property p_maker;
        $stable(regBank[ADDR_MAKER_ID]);
    endproperty
    property p_idle_stable;
        idle >= 4'h8 |=> $stable(regBank[ADDR_CHANNEL]);
    endproperty
    property p_enn_idle;
        selN [*3] |-> misoEnN;
    endproperty
    property p_start_set;
        ctl.txStart |-> ##[0:2] regBank[ADDR_TX_CONTROL][BIT_TX_START];
    endproperty
    // a start written in the done cycle wins and shows as a pulse one clock on
    property p_start_clear;
        txDone |=> !regBank[ADDR_TX_CONTROL][BIT_TX_START] || ctl.txStart;
    endproperty
    property p_pulse;
        ctl.txStart || ctl.outPush |=> !ctl.txStart && !ctl.outPush;
    endproperty
    property p_flush_zero;
        regBank[ADDR_TX_CONTROL][BIT_TX_FLUSH] == 1'b0;
    endproperty

    a_reset_values: assert property (p_reset_values) else $error("bad reset");
    a_chan_top: assert property (p_chan_top) else $error("channel top bit set");
    a_cfg_unused: assert property (p_cfg_unused) else $error("unused bits set");
    a_ovrd_mask: assert property (p_ovrd_mask) else $error("override mask");
    a_maker: assert property (p_maker) else $error("identity changed");
    a_idle_stable: assert property (p_idle_stable) else $error("change without frame");
    a_enn_idle: assert property (p_enn_idle) else $error("miso driven when idle");
    a_start_set: assert property (p_start_set) else $error("start bit not set");
    a_start_clear: assert property (p_start_clear) else $error("start bit not cleared");
    a_pulse: assert property (p_pulse) else $error("command not a pulse");
    a_flush_zero: assert property (p_flush_zero) else $error("flush bit stored");

    c_start: cover property (ctl.txStart);
    c_push: cover property (ctl.outPush);
    c_done: cover property (txDone && regBank[ADDR_TX_CONTROL][BIT_TX_START]);
endmodule

bind rrbsa_bank rrbsa_bank_props i_rrbsa_bank_props (
    .clock   (clock),
    .rst     (rst),
    .selN    (selN),
    .misoEnN (misoEnN),
    .txDone  (txDone),
    .regBank (regBank),
    .ctl     (ctl)
);

// [dv/rrbsa_master.sv]
`timescale 1ns/10ps
// ========================================
// serial master; link clock stands still outside bytes
module rrbsa_master
    import rrbsa_pkg::*;
(
    output logic      sclk,     // link clock, 64 ns
    output logic      selN,     // frame select
    output logic      mosi,     // data to device
    input  wire logic misoOut,  // data from device
    input  wire logic misoEnN   // low while device drives
);
    initial begin
        sclk = 1'b0;
        selN = 1'b1;
        mosi = 1'b0;
    end

    // msb first; sample miso on falling edge, undriven line reads inverted
    task automatic shift(input rrbsa_reg_t b, output rrbsa_reg_t r);
        for (int i = 7; i >= 0; i--) begin
            mosi = b[i];
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
            r[i] = (misoEnN === 1'b0) ? misoOut : ~misoOut;
        end
        mosi = ~mosi;
        #512;
    endtask

    // command byte first, then n data bytes
    task automatic xfer(input rrbsa_reg_t cmd, input int n,
                        input rrbsa_reg_t wd [8], output rrbsa_reg_t rd [8]);
        rrbsa_reg_t junk;
        selN = 1'b0;
        #20 shift(cmd, junk);
        for (int k = 0; k < n; k++) shift(wd[k], rd[k]);
        selN = 1'b1;
        #512;
    endtask
endmodule

// [dv/radio_register_bank_serial_access_tb.sv]
`timescale 1ns/10ps
module radio_register_bank_serial_access_tb
    import rrbsa_pkg::*;
();
    logic          clock    = 1'b0;
    logic          rst      = 1'b0;
    logic          sclk;
    logic          selN;
    logic          mosi;
    logic          misoOut;
    logic          misoEnN;
    logic [3:0]    pinLevel = 4'h0;
    logic          txDone   = 1'b0;
    rrbsa_status_t status   = '0;
    rrbsa_bank_t   regBank;
    rrbsa_ctl_t    ctl;
    logic [31:0]   lfsr     = 32'hAC798DD1;
    int            n_errors = 0;
    int            checked  = 0;
    int            nStart   = 0;
    int            nFlush   = 0;
    int            nPush    = 0;
    int            nFlagRd  = 0;
    int            nPop     = 0;
    rrbsa_reg_t    wd [8];
    rrbsa_reg_t    rd [8];

    always #25 clock = ~clock;

    rrbsa_bank i_rrbsa_bank (.clock(clock), .rst(rst), .sclk(sclk), .selN(selN),
        .mosi(mosi), .misoOut(misoOut), .misoEnN(misoEnN), .pinLevel(pinLevel),
        .txDone(txDone), .status(status), .regBank(regBank), .ctl(ctl));
    rrbsa_master i_rrbsa_master (.sclk(sclk), .selN(selN), .mosi(mosi),
        .misoOut(misoOut), .misoEnN(misoEnN));

    always @(posedge clock) begin
        if (ctl.txStart === 1'b1) nStart++;
        if (ctl.txFlush === 1'b1) nFlush++;
        if (ctl.outPush === 1'b1) nPush++;
        if (ctl.txFlagsRead === 1'b1) nFlagRd++;
        if (ctl.inPop === 1'b1) nPop++;
    end

    function automatic void rnd(output rrbsa_reg_t v);
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        v = lfsr[7:0];
    endfunction
    function automatic rrbsa_reg_t pin_view(input rrbsa_reg_t d, input logic [3:0] p);
        return {d[7:4], p};
    endfunction
    task automatic chk(input string what, input rrbsa_reg_t seen, input rrbsa_reg_t exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input rrbsa_reg_t d);
        wd[0] = d;
        i_rrbsa_master.xfer({2'b10, a}, 1, wd, rd);
    endtask
    task automatic rdb(input logic [5:0] a, input int n, input logic inc);
        i_rrbsa_master.xfer({1'b0, inc, a}, n, wd, rd);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #2000000;
        n_errors++;
        complete_run();
    end

    initial begin
        rrbsa_reg_t v;
        rrbsa_reg_t d;
        logic [6:0] ch;
        logic [5:0] ta [5];
        rrbsa_reg_t te [5];
        ta = '{ADDR_POWER, ADDR_FRAMING, ADDR_MAKER_ID, ADDR_STATE_OVRD, ADDR_CLK_GATE};
        te = '{8'hA0, 8'hA5, MAKER_ID, 8'h00, 8'h00};
        // a real rising edge, or the link-side flops never leave unknown
        rst <= 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rnd(v);
        rnd(d);
        @(posedge clock);
        status.txCrc <= {v, d};
        status.inData <= v ^ d;
        rdb(ADDR_CHANNEL, 4, 1'b1);
        chk("chan", rd[0], 8'h48);
        chk("len", rd[1], 8'h00);
        chk("txctl", rd[2], 8'h03);
        chk("txcfg", rd[3], 8'h05);
        chk("flagrd", 8'(nFlagRd), 8'h01);
        for (int i = 0; i < 5; i++) begin
            rdb(ta[i], 1, 1'b0);
            chk("single", rd[0], te[i]);
        end
        rdb(ADDR_POWER, 3, 1'b0);
        for (int i = 0; i < 3; i++) chk("poll", rd[i], 8'hA0);
        rdb(ADDR_IN_BUFFER, 2, 1'b0);
        chk("inbuf0", rd[0], status.inData);
        chk("inbuf1", rd[1], status.inData);
        chk("pops", 8'(nPop), 8'h03);
        for (int r = 0; r < 4; r++) begin
            rnd(v);
            rnd(d);
            wd[0] = v;
            wd[1] = d;
            i_rrbsa_master.xfer({2'b11, ADDR_SEED_LOW}, 2, wd, rd);
            rdb(ADDR_SEED_HIGH, 1, 1'b0);
            chk("seedh", rd[0], d);
            rdb(ADDR_EOP_CONTROL, 2, 1'b1);
            chk("eop", rd[0], 8'hA4);
            chk("seedl", rd[1], v);
            // channel kept within 0..0x62
            ch = 7'(v % 8'h63);
            wr(ADDR_CHANNEL, {1'b1, ch});
            rdb(ADDR_CHANNEL, 1, 1'b0);
            chk("chan", rd[0], {1'b0, ch});
            @(posedge clock);
            pinLevel <= d[3:0];
            wr(ADDR_PIN_LEVEL, v);
            rdb(ADDR_PIN_LEVEL, 1, 1'b0);
            chk("pins", rd[0], pin_view(v, d[3:0]));
            wr(ADDR_STATE_OVRD, d);
            wr(ADDR_MAKER_ID, d);
            wr(ADDR_TX_CRC_LOW, d);
            rdb(ADDR_STATE_OVRD, 1, 1'b0);
            chk("ovrd", rd[0], 8'h00);
            rdb(ADDR_MAKER_ID, 1, 1'b0);
            chk("maker", rd[0], MAKER_ID);
            rdb(ADDR_TX_CRC_LOW, 2, 1'b1);
            chk("crcl", rd[0], status.txCrc[7:0]);
            chk("crch", rd[1], status.txCrc[15:8]);
        end
        rnd(d);
        wr(ADDR_TX_CONTROL, {2'b10, d[5:0]});
        wr(ADDR_TX_CONTROL, {2'b00, d[5:0]});
        rdb(ADDR_TX_CONTROL, 1, 1'b0);
        chk("go", rd[0], {2'b10, d[5:0]});
        chk("starts", 8'(nStart), 8'h01);
        @(posedge clock);
        txDone <= 1'b1;
        repeat (2) @(posedge clock);
        txDone <= 1'b0;
        rdb(ADDR_TX_CONTROL, 1, 1'b0);
        chk("done", rd[0], {2'b00, d[5:0]});
        wr(ADDR_TX_CONTROL, {2'b01, d[5:0]});
        rdb(ADDR_TX_CONTROL, 1, 1'b0);
        chk("flush", rd[0], {2'b00, d[5:0]});
        chk("flushes", 8'(nFlush), 8'h01);
        for (int i = 0; i < 3; i++) rnd(wd[i]);
        d = wd[2];
        i_rrbsa_master.xfer({2'b10, ADDR_OUT_BUFFER}, 3, wd, rd);
        chk("pushes", 8'(nPush), 8'h03);
        chk("outdata", ctl.outData, d);
        // second reset in mid-run must restore the image
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rdb(ADDR_CHANNEL, 1, 1'b0);
        chk("rstchan", rd[0], 8'h48);
        complete_run();
    end
endmodule
